// ### led_pkg.sv
`default_nettype none
package led_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_STATUS    = 8'h60;
    localparam logic [7:0] IDX_LINK      = 8'h72;
    localparam logic [7:0] IDX_POLARITY  = 8'h73;
    localparam logic [7:0] IDX_DRIVE     = 8'h74;
    localparam logic [7:0] IDX_BEH_LOW   = 8'h81;
    localparam logic [7:0] IDX_BEH_HIGH  = 8'h82;
    localparam logic [7:0] IDX_P1_PERIOD = 8'h84;
    localparam logic [7:0] IDX_P2_PERIOD = 8'h85;
    localparam logic [7:0] IDX_BR_PERIOD = 8'h86;
    localparam logic [7:0] IDX_CONFIG    = 8'h88;
    localparam logic [7:0] IDX_DUTY      = 8'h90;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BEH       = 8'h00;
    localparam logic [5:0] RST_LED6      = 6'h00;
    localparam logic [7:0] RST_P1_PERIOD = 8'h20;
    localparam logic [6:0] RST_P2_PERIOD = 7'h14;
    localparam logic [6:0] RST_BR_PERIOD = 7'h5d;
    localparam logic [6:0] RST_CONFIG    = 7'h04;
    localparam logic [7:0] RST_DUTY      = 8'hf0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SEL_W          = 2;
    localparam int BEH_LOW_LEDS   = 4;
    localparam int EDGE_SEL_BIT   = 7;
    localparam int P1_CNT_LSB     = 0;
    localparam int P2_CNT_LSB     = 3;
    localparam int DUTY_MAX_LSB   = 4;
    localparam int DUTY_MIN_LSB   = 0;

    // ------------------------------------------------------------
    // Behaviour codes and sequencer states
    // ------------------------------------------------------------
    localparam logic [1:0] BEH_DIRECT  = 2'b00;
    localparam logic [1:0] BEH_PULSE1  = 2'b01;
    localparam logic [1:0] BEH_PULSE2  = 2'b10;
    localparam logic [1:0] BEH_BREATHE = 2'b11;

    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_ACTIVE = 2'b01,
        SEQ_TAIL   = 2'b10
    } seq_state_t;

    // ------------------------------------------------------------
    // Timing: period LSB is 32 ms, split into 32 ramp steps
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int PERIOD_LSB_MS = 32;
    localparam int PHASE_W       = $clog2(PERIOD_LSB_MS);

endpackage : led_pkg
`default_nettype wire

// ### led_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface led_cfg_if;
    logic       ms_tick;
    logic       edge_sel;
    logic [2:0] p1_cnt;
    logic [2:0] p2_cnt;
    logic [6:0] p1_per;
    logic [6:0] p2_per;
    logic [6:0] br_per;
    logic [3:0] duty_max;
    logic [3:0] duty_min;

    modport src (output ms_tick, edge_sel, p1_cnt, p2_cnt, p1_per, p2_per, br_per,
                 duty_max, duty_min);
    modport seq (input ms_tick, edge_sel, p1_cnt, p2_cnt, p1_per, p2_per, br_per,
                 duty_max, duty_min);
endinterface : led_cfg_if
`default_nettype wire

// ### led_seq.sv
`timescale 1ns/1ps
`default_nettype none
module led_seq (
    // Clock, reset and enable
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Shared settings
    led_cfg_if.seq          cfg,
    // Per-LED control
    input  wire logic [1:0] sel,
    input  wire logic       linked,
    input  wire logic       touch,
    input  wire logic       drive,
    // Result
    output logic      [3:0] level,
    output logic            active
);
    typedef struct packed {
        led_pkg::seq_state_t st;
        logic [2:0]          cnt;
        logic [4:0]          phase;
        logic [6:0]          stepc;
        logic                prev;
        logic [3:0]          lmax;
        logic [3:0]          lmin;
        logic [6:0]          lper;
    } seq_reg_t;

    seq_reg_t   q;
    seq_reg_t   d;
    logic       src;
    logic       rise;
    logic       fall;
    logic       start1;
    logic       step;
    logic       wrap;
    logic [6:0] per_live;
    logic [6:0] per_eff;
    logic [6:0] per1;
    logic [3:0] max_eff;
    logic [3:0] min_eff;
    logic [3:0] span;
    logic [3:0] tri_lvl;
    logic [8:0] prod;

    always_comb begin
        src      = linked ? touch : drive;                          // RULE3 RULE4
        rise     = src & ~q.prev;
        fall     = ~src & q.prev;                                   // RULE15
        start1   = cfg.edge_sel ? fall : rise;                      // RULE17
        unique case (sel)
            led_pkg::BEH_PULSE1: per_live = cfg.p1_per;
            led_pkg::BEH_PULSE2: per_live = cfg.p2_per;
            default:             per_live = cfg.br_per;
        endcase
        // Unlinked LEDs run on settings caught at actuation
        per_eff  = linked ? per_live     : q.lper;                  // RULE11
        max_eff  = linked ? cfg.duty_max : q.lmax;
        min_eff  = linked ? cfg.duty_min : q.lmin;
        per1     = (per_eff == 7'h00) ? 7'h01 : per_eff;
        step     = cfg.ms_tick && (q.stepc >= per1 - 7'h01);        // RULE19
        wrap     = step && (q.phase == 5'h1f);
        d        = q;
        d.prev   = src;
        if (cfg.ms_tick) begin
            d.stepc = step ? 7'h00 : q.stepc + 7'h01;
        end
        if (step) begin
            d.phase = q.phase + 5'h01;
        end
        unique case (q.st)
            led_pkg::SEQ_IDLE: begin
                if ((sel == led_pkg::BEH_PULSE1) ? start1 : rise) begin // RULE5 RULE12
                    d.st    = led_pkg::SEQ_ACTIVE;
                    d.cnt   = cfg.p1_cnt;                           // RULE18
                    d.phase = 5'h00;
                    d.stepc = 7'h00;
                    d.lmax  = cfg.duty_max;
                    d.lmin  = cfg.duty_min;
                    d.lper  = per_live;
                end
            end
            led_pkg::SEQ_ACTIVE: begin
                unique case (sel)                                   // RULE13 RULE14
                    led_pkg::BEH_PULSE1: begin
                        if (wrap) begin                             // RULE8
                            d.st  = (q.cnt == 3'h0) ? led_pkg::SEQ_IDLE : led_pkg::SEQ_ACTIVE;
                            d.cnt = q.cnt - 3'h1;
                        end
                    end
                    led_pkg::BEH_PULSE2: begin
                        if (fall) begin                             // RULE9
                            d.st  = led_pkg::SEQ_TAIL;
                            d.cnt = cfg.p2_cnt;                     // RULE18
                        end
                    end
                    default: begin
                        if (fall) begin                             // RULE7 RULE10
                            d.st = led_pkg::SEQ_IDLE;
                        end
                    end
                endcase
            end
            led_pkg::SEQ_TAIL: begin
                if (rise) begin
                    d.st = led_pkg::SEQ_ACTIVE;
                end else if (wrap) begin                            // RULE9
                    d.st  = (q.cnt == 3'h0) ? led_pkg::SEQ_IDLE : led_pkg::SEQ_TAIL;
                    d.cnt = q.cnt - 3'h1;
                end
            end
            default: d.st = led_pkg::SEQ_IDLE;
        endcase
        // Triangle over one period: up for half, down for half
        tri_lvl  = q.phase[4] ? ~q.phase[3:0] : q.phase[3:0];       // RULE10
        span     = (max_eff > min_eff) ? max_eff - min_eff : 4'h0;
        prod     = {5'h00, span} * ({5'h00, tri_lvl} + 9'h001);
        if (q.st == led_pkg::SEQ_IDLE) begin
            level = min_eff;
        end else if (sel == led_pkg::BEH_DIRECT) begin
            level = max_eff;                                        // RULE7
        end else begin
            level = min_eff + prod[7:4];
        end
        active   = (q.st != led_pkg::SEQ_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    direct_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        ce && sel == led_pkg::BEH_DIRECT && q.st == led_pkg::SEQ_IDLE && rise
        |=> q.st == led_pkg::SEQ_ACTIVE) else $error("Direct did not turn on");
    direct_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        ce && sel == led_pkg::BEH_DIRECT && q.st == led_pkg::SEQ_ACTIVE && fall
        |=> q.st == led_pkg::SEQ_IDLE) else $error("Direct did not turn off");
    pulse1_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        ce && sel == led_pkg::BEH_PULSE1 && q.st == led_pkg::SEQ_ACTIVE && !wrap
        |=> q.st == led_pkg::SEQ_ACTIVE) else $error("Pulse 1 ended early");
    pulse2_tail_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        ce && sel == led_pkg::BEH_PULSE2 && q.st == led_pkg::SEQ_ACTIVE && fall
        |=> q.st == led_pkg::SEQ_TAIL && q.cnt == $past(cfg.p2_cnt))
        else $error("Pulse 2 tail not entered");
    idle_level_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
        ce && q.st != led_pkg::SEQ_IDLE && d.st == led_pkg::SEQ_IDLE && linked
        |=> level == cfg.duty_min || !linked) else $error("Idle level not minimum");

endmodule : led_seq
`default_nettype wire

// ### led_behavior_engine.sv
// Operation
// RULE1: Each of six LEDs has its own 2-bit behaviour selector.
// RULE2: LED1-4 selectors in low register, LED5-6 in high; both reset zero.
// RULE3: Linked LED starts and stops behaviour on touch and release.
// RULE4: Unlinked LED treats drive bit set as touch, clear as release.
// RULE5: Behaviour begins on its start trigger, ends on its stop trigger.
// RULE6: Polarity decides the pin level while the LED is not actuated.
// RULE7: Direct drives active on touch or set, inactive on release or clear.
// RULE8: Pulse 1 emits a counted number of up-down pulses, no stop trigger.
// RULE9: Pulse 2 pulses until stop, then counted pulses, then minimum.
// RULE10: Breathe ramps between min and max duty, each ramp half period.
// RULE11: Unlinked breathing LED keeps old settings until drive re-set.
// RULE12: Unlinked Pulse 1 ignores drive bit until sequence completes.
// RULE13: Selector change on actuated unlinked LED applies at once.
// RULE14: Link change follows new source for Direct, Breathe; pulses finish.
// RULE15: After link change an inactive new source acts as a release.
// RULE16: PWM rate follows behaviour; Direct uses maximum PWM rate. Code runs every behaviour on one full-clock-rate PWM.
// RULE17: Pulse 1 starts on set when edge select is zero, clear when one.
// RULE18: Pulse counts are 3-bit fields giving value plus one pulses.
// RULE19: Period settings count 32 ms per LSB.
// RULE20: Six independent sequencers share period and duty settings.
`timescale 1ns/1ps
`default_nettype none
module led_behavior_engine #(
    parameter int MS_CYCLES = led_pkg::MS_CYCLES,
    parameter int NUM_LEDS  = 6,
    parameter int ADDR_W    = 12
) (
    // Clock, reset, enable
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Touch sense results, asynchronous
    input  wire logic [NUM_LEDS-1:0] touch_in,
    // LED pins
    output logic      [NUM_LEDS-1:0] led_pin
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NUM_LEDS-1:0] link;
        logic [NUM_LEDS-1:0] pol;
        logic [NUM_LEDS-1:0] drive;
        logic [7:0]          beh_lo;
        logic [7:0]          beh_hi;
        logic [7:0]          p1_per;
        logic [6:0]          p2_per;
        logic [6:0]          br_per;
        logic [6:0]          pulse_cfg;
        logic [7:0]          duty;
        logic [NUM_LEDS-1:0] s1;
        logic [NUM_LEDS-1:0] s2;
        logic [NUM_LEDS-1:0] s3;
        logic [NUM_LEDS-1:0] touch;
        logic [31:0]         msc;
        logic                tick;
        logic [3:0]          pwm;
        logic [31:0]         rdata;
        logic [NUM_LEDS-1:0] pin;
    } top_reg_t;

    top_reg_t            q;
    top_reg_t            d;
    logic                setup;
    logic                wr;
    logic [7:0]          idx;
    logic                hit;
    logic [31:0]         rd_mux;
    logic [NUM_LEDS-1:0] pwm_on;
    logic [NUM_LEDS-1:0] act;
    logic [3:0]          lvl [NUM_LEDS];

    led_cfg_if cfg ();

    assign cfg.ms_tick  = q.tick;
    assign cfg.edge_sel = q.p1_per[led_pkg::EDGE_SEL_BIT];
    assign cfg.p1_cnt   = q.pulse_cfg[led_pkg::P1_CNT_LSB +: 3];
    assign cfg.p2_cnt   = q.pulse_cfg[led_pkg::P2_CNT_LSB +: 3];
    assign cfg.p1_per   = q.p1_per[6:0];
    assign cfg.p2_per   = q.p2_per;
    assign cfg.br_per   = q.br_per;
    assign cfg.duty_max = q.duty[led_pkg::DUTY_MAX_LSB +: 4];
    assign cfg.duty_min = q.duty[led_pkg::DUTY_MIN_LSB +: 4];

    // ------------------------------------------------------------
    // Sequencers
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_LEDS; i++) begin : g_led
        logic [1:0] sel;
        if (i < led_pkg::BEH_LOW_LEDS) begin : g_lo
            assign sel = q.beh_lo[i*led_pkg::SEL_W +: led_pkg::SEL_W];     // RULE1 RULE2
        end else begin : g_hi
            assign sel = q.beh_hi[(i-led_pkg::BEH_LOW_LEDS)*led_pkg::SEL_W +: led_pkg::SEL_W];
        end
        led_seq u_seq (                                                    // RULE20
            .pclk    (pclk),
            .presetn (presetn),
            .ce      (ce),
            .cfg     (cfg.seq),
            .sel     (sel),
            .linked  (q.link[i]),
            .touch   (q.touch[i]),
            .drive   (q.drive[i]),
            .level   (lvl[i]),
            .active  (act[i])
        );
        // Free-running PWM at full clock rate for every behaviour
        assign pwm_on[i] = (q.pwm < lvl[i]);                               // RULE16
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite & hit;
    assign idx     = paddr[9:2];
    assign pready  = ce;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = q.rdata;

    always_comb begin
        hit = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
        unique case (idx)
            led_pkg::IDX_STATUS:    rd_mux = {26'h0, act};
            led_pkg::IDX_LINK:      rd_mux = {26'h0, q.link};
            led_pkg::IDX_POLARITY:  rd_mux = {26'h0, q.pol};
            led_pkg::IDX_DRIVE:     rd_mux = {26'h0, q.drive};
            led_pkg::IDX_BEH_LOW:   rd_mux = {24'h0, q.beh_lo};
            led_pkg::IDX_BEH_HIGH:  rd_mux = {24'h0, q.beh_hi};
            led_pkg::IDX_P1_PERIOD: rd_mux = {24'h0, q.p1_per};
            led_pkg::IDX_P2_PERIOD: rd_mux = {25'h0, q.p2_per};
            led_pkg::IDX_BR_PERIOD: rd_mux = {25'h0, q.br_per};
            led_pkg::IDX_CONFIG:    rd_mux = {25'h0, q.pulse_cfg};
            led_pkg::IDX_DUTY:      rd_mux = {24'h0, q.duty};
            default: begin
                rd_mux = 32'h0;
                hit    = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (setup) begin
            d.rdata = rd_mux;
        end
        if (wr) begin
            unique case (idx)
                led_pkg::IDX_LINK:      d.link   = pwdata[NUM_LEDS-1:0];
                led_pkg::IDX_POLARITY:  d.pol    = pwdata[NUM_LEDS-1:0];
                led_pkg::IDX_DRIVE:     d.drive  = pwdata[NUM_LEDS-1:0];   // RULE4
                led_pkg::IDX_BEH_LOW:   d.beh_lo = pwdata[7:0];            // RULE2
                led_pkg::IDX_BEH_HIGH:  d.beh_hi = {4'h0, pwdata[3:0]};    // RULE2
                led_pkg::IDX_P1_PERIOD: d.p1_per = pwdata[7:0];            // RULE17
                led_pkg::IDX_P2_PERIOD: d.p2_per = pwdata[6:0];
                led_pkg::IDX_BR_PERIOD: d.br_per = pwdata[6:0];
                led_pkg::IDX_CONFIG:    d.pulse_cfg = pwdata[6:0];         // RULE18
                led_pkg::IDX_DUTY:      d.duty   = pwdata[7:0];
                default:                d.duty   = q.duty;
            endcase
        end
        // Only s2 and s3 are compared; s1 may be metastable
        d.s1 = touch_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int k = 0; k < NUM_LEDS; k++) begin
            if (q.s2[k] == q.s3[k]) begin
                d.touch[k] = q.s2[k];                                      // RULE3
            end
        end
        d.tick = (q.msc == 32'(MS_CYCLES - 1));                            // RULE19
        d.msc  = d.tick ? 32'h0 : q.msc + 32'h1;
        d.pwm  = q.pwm + 4'h1;
        // Polarity zero sinks current: LED on means pin low
        d.pin  = ~(pwm_on ^ q.pol);                                        // RULE6
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.link   <= led_pkg::RST_LED6;
            q.pol    <= led_pkg::RST_LED6;
            q.drive  <= led_pkg::RST_LED6;
            q.beh_lo <= led_pkg::RST_BEH;
            q.beh_hi <= led_pkg::RST_BEH;
            q.p1_per <= led_pkg::RST_P1_PERIOD;
            q.p2_per <= led_pkg::RST_P2_PERIOD;
            q.br_per <= led_pkg::RST_BR_PERIOD;
            q.pulse_cfg <= led_pkg::RST_CONFIG;
            q.duty   <= led_pkg::RST_DUTY;
            // Dark through reset: default polarity sinks, so off is high
            q.pin    <= '1;                                            // RULE6
        end else if (ce) begin
            q <= d;
        end
    end

    assign led_pin = q.pin;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    beh_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        ce && wr && idx == led_pkg::IDX_BEH_LOW |=> q.beh_lo == $past(pwdata[7:0]))
        else $error("Low behaviour write lost");
    beh_upper_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        q.beh_hi[7:4] == 4'h0) else $error("High behaviour upper bits set");
    pin_polarity_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        ce |=> led_pin == $past(~(pwm_on ^ q.pol))) else $error("Pin polarity wrong");

endmodule : led_behavior_engine
`default_nettype wire

// ### led_load.sv
`timescale 1ns/1ps
`default_nettype none
module led_load (
    // Clock
    input  wire logic       pclk,
    // Pins and their polarity
    input  wire logic [5:0] led_pin,
    input  wire logic [5:0] pol,
    // Measurement control
    input  wire logic [2:0] which,
    input  wire logic       clr,
    // Result
    output logic      [4:0] lit_cnt
);
    // ------------------------------------------------------------
    // Lit-cycle counter, one LED at a time
    // ------------------------------------------------------------
    // Sixteen samples span one whole PWM frame, so the count is the level
    always_ff @(posedge pclk) begin
        if (clr) begin
            lit_cnt <= 5'h00;
        end else if (led_pin[which] === pol[which]) begin
            lit_cnt <= lit_cnt + 5'h01;
        end
    end
endmodule : led_load
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic [5:0]  touch_in, led_pin, pol_v;
    logic [2:0]  which;
    logic [4:0]  lit_cnt;
    logic        err_v;
    logic        ce = 1'b1;
    logic [15:0] lfsr_q = 16'ha176;
    int          bad_count = 0;
    int          checked = 0;

    always #12.5 pclk = ~pclk;

    // Short ms tick keeps the 32 ms steps to 128 cycles
    led_behavior_engine #(.MS_CYCLES(4)) led_behavior_engine_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .touch_in(touch_in), .led_pin(led_pin));
    led_load led_load_i (.pclk(pclk), .led_pin(led_pin), .pol(pol_v), .which(which),
        .clr(clr), .lit_cnt(lit_cnt));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        if (bad_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a stalled access
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v    = prdata;
        err_v   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(idx, 1'b1, {24'h0, d});
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
        apb(idx, 1'b0, 32'h0);
        check(name, rd_v, exp);
    endtask : rd_chk

    task automatic lit_chk(input string name, input logic [2:0] led, input logic [4:0] exp);
        @(posedge pclk);
        which <= led;
        clr   <= 1'b1;
        @(posedge pclk);
        clr   <= 1'b0;
        repeat (17) @(posedge pclk);
        check(name, {27'h0, lit_cnt}, {27'h0, exp});
    endtask : lit_chk

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, touch_in, clr, which, pol_v} = '0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("beh_low_reset", 8'h81, 32'h0);
        rd_chk("beh_high_reset", 8'h82, 32'h0);
        for (int k = 0; k < 4; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            wr(8'h81, lfsr_q[7:0]);
            wr(8'h82, lfsr_q[15:8]);
            rd_chk("beh_low", 8'h81, {24'h0, lfsr_q[7:0]});
            rd_chk("beh_high", 8'h82, {28'h0, lfsr_q[11:8]});
        end
        apb(8'h01, 1'b0, 32'h0);
        check("unmapped_err", {31'h0, err_v}, 32'h1);
        wr(8'h81, 8'h00);
        wr(8'h82, 8'h00);
        lit_chk("direct_off", 3'd0, 5'd0);
        wr(8'h74, 8'h01);
        lit_chk("direct_on", 3'd0, 5'd15);
        // Duty latched at actuation for host-driven LEDs
        wr(8'h90, 8'h90);
        lit_chk("duty_held", 3'd0, 5'd15);
        wr(8'h74, 8'h00);
        wr(8'h74, 8'h01);
        lit_chk("duty_new", 3'd0, 5'd9);
        wr(8'h73, 8'h01);
        pol_v <= 6'h01;
        wr(8'h74, 8'h00);
        repeat (3) @(posedge pclk);
        check("idle_pin_pol1", {31'h0, led_pin[0]}, 32'h0);
        wr(8'h73, 8'h00);
        pol_v <= 6'h00;
        wr(8'h90, 8'hf0);
        repeat (3) @(posedge pclk);
        check("idle_pin_pol0", {31'h0, led_pin[0]}, 32'h1);
        wr(8'h72, 8'h02);
        touch_in <= 6'h02;
        repeat (8) @(posedge pclk);
        lit_chk("touch_on", 3'd1, 5'd15);
        touch_in <= 6'h00;
        repeat (8) @(posedge pclk);
        lit_chk("touch_off", 3'd1, 5'd0);
        wr(8'h72, 8'h00);
        wr(8'h74, 8'h01);
        wr(8'h72, 8'h01);
        lit_chk("link_release", 3'd0, 5'd0);
        wr(8'h72, 8'h00);
        lit_chk("unlink_follow", 3'd0, 5'd15);
        wr(8'h74, 8'h00);
        // Pulse 1, three pulses of 128 cycles
        wr(8'h84, 8'h01);
        wr(8'h88, 8'h02);
        wr(8'h81, 8'h01);
        wr(8'h74, 8'h01);
        repeat (300) @(posedge pclk);
        rd_chk("p1_running", 8'h60, 32'h1);
        wr(8'h74, 8'h00);
        wr(8'h74, 8'h01);
        repeat (120) @(posedge pclk);
        rd_chk("p1_done", 8'h60, 32'h0);
        wr(8'h84, 8'h81);
        wr(8'h88, 8'h00);
        wr(8'h74, 8'h00);
        rd_chk("p1_clear_start", 8'h60, 32'h1);
        repeat (200) @(posedge pclk);
        wr(8'h74, 8'h01);
        repeat (5) @(posedge pclk);
        rd_chk("p1_set_nostart", 8'h60, 32'h0);
        // Pulse 2 repeats until release, then one tail pulse
        wr(8'h84, 8'h01);
        wr(8'h81, 8'h02);
        wr(8'h85, 8'h01);
        wr(8'h74, 8'h00);
        wr(8'h74, 8'h01);
        repeat (400) @(posedge pclk);
        rd_chk("p2_repeat", 8'h60, 32'h1);
        wr(8'h74, 8'h00);
        repeat (60) @(posedge pclk);
        rd_chk("p2_tail", 8'h60, 32'h1);
        repeat (300) @(posedge pclk);
        rd_chk("p2_done", 8'h60, 32'h0);
        wr(8'h81, 8'h03);
        wr(8'h86, 8'h01);
        wr(8'h74, 8'h01);
        repeat (300) @(posedge pclk);
        rd_chk("breathe_run", 8'h60, 32'h1);
        // Enable low must freeze the running ramp and the PWM
        ce <= 1'b0;
        @(posedge pclk);
        rd_v = {26'h0, led_pin};
        repeat (21) @(posedge pclk);
        check("ce_freeze", {26'h0, led_pin}, rd_v);
        ce <= 1'b1;
        wr(8'h74, 8'h00);
        repeat (5) @(posedge pclk);
        rd_chk("breathe_stop", 8'h60, 32'h0);
        end_sim();
    end
endmodule : tb
`default_nettype wire
